// ---- include/pitc_map.svh ----
// Purpose: register offsets, field positions and reset values of the irq/thermal block
// Assumes: APB byte addresses, one 32-bit word per register, data in bits 7:0
// Notes: offsets are local to this block
`ifndef PITC_MAP_SVH
`define PITC_MAP_SVH
// group register offsets: group g at base + 0x10*g
`define PITC_GRP_BASE 12'h000
`define PITC_GRP_STRIDE 12'h010
`define PITC_OFS_FLAGS 12'h000
`define PITC_OFS_BLOCK 12'h004
`define PITC_OFS_LIVE 12'h008
`define PITC_OFS_RISE 12'h048
`define PITC_OFS_FALL 12'h04c
`define PITC_OFS_IRQ_CTRL 12'h050
`define PITC_OFS_THERM_CFG 12'h054
`define PITC_OFS_SYS_STAT 12'h058
// interrupt control fields
`define PITC_CTRL_POL_BIT 0
`define PITC_CTRL_CLR_BIT 1
`define PITC_CTRL_PEND_BIT 2
// thermal config fields
`define PITC_THERM_HDSEL_LO 0
`define PITC_THERM_HDSEL_HI 1
`define PITC_THERM_OFFSLEEP_BIT 2
`define PITC_THERM_IRQSLEEP_BIT 3
// first group hot-die bit
`define PITC_HOT_DIE_BIT 5
// reset values
`define PITC_BLOCK_RST 8'hff
`define PITC_RISE_RST 8'h00
`define PITC_FALL_RST 8'h00
`define PITC_CTRL_RST 8'h00
`define PITC_THERM_RST 8'h00
// hot-die hysteresis in temperature codes
`define PITC_HD_HYST 8'h0a
// shutdown temperature code (degrees C)
`define PITC_TS_LIMIT 8'h94
// hot-die threshold codes (degrees C)
`define PITC_HD_THR0 8'h75
`define PITC_HD_THR1 8'h79
`define PITC_HD_THR2 8'h7d
`define PITC_HD_THR3 8'h82
`endif

// ---- include/pitc_pkg.sv ----
// Purpose: shared types of the irq/thermal block
// Assumes: nothing
// Notes: constants sit in pitc_map.svh
package pitc_pkg;
  typedef enum logic [1:0] {
    PITC_OFF = 2'b00,
    PITC_ACTIVE = 2'b01,
    PITC_SLEEP = 2'b10,
    PITC_BACKUP = 2'b11
  } pitc_pwr_t;
  typedef logic [7:0] pitc_byte_t;
endpackage

// ---- include/pitc_evt_if.sv ----
// Purpose: carries one group's events and clear requests between modules
// Assumes: single clock
// Notes: used between top and pitc_evt_group
`timescale 1ns/1ps
interface pitc_evt_if;
  logic [7:0] evt;
  logic [7:0] block;
  logic [7:0] clrBits;
  logic clrAll;
  logic lineActive;
  logic pendEn;
  logic [7:0] flags;
  modport ctrl (
    output evt,
    output block,
    output clrBits,
    output clrAll,
    output lineActive,
    output pendEn,
    input flags
  );
  modport grp (
    input evt,
    input block,
    input clrBits,
    input clrAll,
    input lineActive,
    input pendEn,
    output flags
  );
endinterface

// ---- logic/pitc_evt_group.sv ----
// Purpose: one group of eight status bits with one pending level each
// Assumes: events are one-cycle pulses; clears are one-cycle pulses
// Notes: set wins over clear; a pending event refills the bit on clear
`timescale 1ns/1ps
module pitc_evt_group
  import pitc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pitc_evt_if.grp io
);
  logic [7:0] flags_r;
  logic [7:0] pend_r;
  logic [7:0] clr;
  logic [7:0] live;
  logic [7:0] repeatEvt;

  // masked sources see no event at all
  assign live = io.evt & ~io.block;
  assign clr = io.clrAll ? 8'hff : io.clrBits;
  // same source again while the line is active
  assign repeatEvt = live & flags_r & {8{io.lineActive}};

  // status bits: new sources set at once, pending refills one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= 8'h00;
    end else begin
      // masked bits keep their value until cleared
      // fresh sources set at once, also while the line is active
      flags_r <= (flags_r & ~clr) | (live & ~(flags_r & ~clr)) | (clr & pend_r) | repeatEvt;
    end
  end

  // one pending level per source, latest wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r <= 8'h00;
    end else begin
      // pending storage only when enabled, else discarded
      pend_r <= (pend_r & ~(clr & flags_r)) | (repeatEvt & {8{io.pendEn}} & ~clr);
    end
  end

  assign io.flags = flags_r;
endmodule

// ---- logic/pitc_edge_sync.sv ----
// Purpose: two-flop synchroniser and edge detector for eight lines
// Assumes: lines are asynchronous pins
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pitc_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] pin,
  output logic [7:0] level,
  output logic [7:0] rise,
  output logic [7:0] fall
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;

  // synchroniser and history stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign level = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule

// ---- logic/pitc_irq_top.sv ----
// Purpose: interrupt aggregator with hot-die and thermal-shutdown monitor, APB registers
// Assumes: 10 MHz clk, synchronous active-low rst_n, die temperature as a code in degrees C
// Notes: APB answers with zero wait states; unmapped reads return zero with pslverr
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pitc_map.svh"
module pitc_irq_top
  import pitc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] srcLevel,
  input wire logic [7:0] gpPin,
  input wire logic [7:0] dieTemp,
  input wire logic [1:0] pwrState,
  input wire logic sleepRequest,
  output logic irqOut,
  output logic sleepGo,
  output logic thermShutdown
);
  logic [7:0] block_r [4];
  logic [7:0] rise_r;
  logic [7:0] fall_r;
  logic [7:0] ctrl_r;
  logic [7:0] therm_r;
  logic [1:0] lastGrp_r;
  logic lastClr_r;
  logic hot_die_event_r;
  logic shutHold_r;
  logic irqOut_r;
  logic sleepGo_r;
  logic shut_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [23:0] lvl1_r;
  logic [23:0] lvl2_r;
  logic [23:0] lvl3_r;
  logic [7:0] gpLevel;
  logic [7:0] gpRise;
  logic [7:0] gpFall;
  logic [7:0] t1_r;
  logic [7:0] t2_r;
  logic [7:0] hdThr;
  logic [7:0] grpEvt [4];
  logic [7:0] grpFlags [4];
  logic [7:0] clrBits [4];
  logic clrAll [4];
  logic lineActive;
  logic anyFlag;
  logic access;
  logic rdEn;
  logic wrEn;
  logic grpHit;
  logic [1:0] grpIdx;
  logic [3:0] grpOfs;
  logic inSleep;
  logic thermOn;
  logic hotEvt;
  logic [1:0] arm_r;
  logic armed;
  logic [8:0] hdLow;
  pitc_pwr_t pwr;

  // bus decode and power-state views; group registers sit in the low 64 bytes
  assign pwr = pitc_pwr_t'(pwrState);
  assign inSleep = (pwr == PITC_SLEEP);
  assign access = psel && penable;
  assign rdEn = access && !pwrite;
  assign wrEn = access && pwrite;
  assign grpIdx = paddr[5:4];
  assign grpOfs = paddr[3:0];
  assign grpHit = (paddr[11:6] == 6'h00) && (grpOfs <= 4'h8) && (paddr[1:0] == 2'b00);

  // source lines come from other domains: two flops before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl1_r <= 24'h000000;
      lvl2_r <= 24'h000000;
      lvl3_r <= 24'h000000;
      t1_r <= 8'h00;
      t2_r <= 8'h00;
    end else begin
      lvl1_r <= srcLevel;
      lvl2_r <= lvl1_r;
      lvl3_r <= lvl2_r;
      t1_r <= dieTemp;
      t2_r <= t1_r;
    end
  end

  pitc_edge_sync gpSync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(gpPin),
    .level(gpLevel),
    .rise(gpRise),
    .fall(gpFall)
  );

  // after reset the sync stages still hold zeros while the pins may sit
  // high; the first compare would look like an edge, so events wait
  // until every stage carries a real pin value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm_r <= 2'h0;
    end else if (arm_r != 2'h3) begin
      arm_r <= arm_r + 2'h1;
    end
  end
  assign armed = (arm_r == 2'h3);

  // thermal protection off in backup and off, optionally off in sleep
  assign thermOn = (pwr == PITC_ACTIVE) ||
    (inSleep && !therm_r[`PITC_THERM_OFFSLEEP_BIT]);

  // hot-die threshold from the two-bit select
  // thresholds rise with the select code, lowest at zero
  always_comb begin
    case (therm_r[`PITC_THERM_HDSEL_HI:`PITC_THERM_HDSEL_LO])
      2'b00: hdThr = `PITC_HD_THR0;
      2'b01: hdThr = `PITC_HD_THR1;
      2'b10: hdThr = `PITC_HD_THR2;
      default: hdThr = `PITC_HD_THR3;
    endcase
  end

  // release point sits the hysteresis below the threshold; nine bits so
  // a hot code near the top of the range cannot wrap and drop the flag
  assign hdLow = {1'b0, t2_r} + {1'b0, `PITC_HD_HYST};

  // hot-die detector with hysteresis, one event per crossing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hot_die_event_r <= 1'b0;
    end else if (!hot_die_event_r && t2_r > hdThr) begin
      hot_die_event_r <= 1'b1;
    end else if (hot_die_event_r && hdLow < {1'b0, hdThr}) begin
      hot_die_event_r <= 1'b0;
    end
  end
  // hot-die event only in active and sleep
  assign hotEvt = !hot_die_event_r && (t2_r > hdThr) &&
    (pwr == PITC_ACTIVE || pwr == PITC_SLEEP);

  // shutdown above limit; restart held until below hot-die threshold
  // the hot-die flag outlives the hold: it needs the die the hysteresis below the threshold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shutHold_r <= 1'b0;
    end else if (thermOn && t2_r > `PITC_TS_LIMIT) begin
      shutHold_r <= 1'b1;
    end else if (t2_r < hdThr) begin
      shutHold_r <= 1'b0;
    end
  end

  // group events: groups 1..3 on both edges except group 1 bit 5 (hot-die and shutdown), group 4 per select
  always_comb begin
    grpEvt[0] = lvl2_r[7:0] ^ lvl3_r[7:0];
    grpEvt[0][`PITC_HOT_DIE_BIT] = hotEvt || (thermOn && !shutHold_r &&
      t2_r > `PITC_TS_LIMIT);
    grpEvt[1] = lvl2_r[15:8] ^ lvl3_r[15:8];
    grpEvt[2] = lvl2_r[23:16] ^ lvl3_r[23:16];
    grpEvt[3] = (gpRise & rise_r) | (gpFall & fall_r);
    // no events while the sync stages fill after reset
    for (int g = 0; g < 4; g++) begin
      if (!armed) begin
        grpEvt[g] = 8'h00;
      end
    end
  end

  // clear requests: read or write per the method bit, one group at a time
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      clrBits[g] = 8'h00;
      clrAll[g] = 1'b0;
    end
    // consecutive clears of the same register count once
    if (grpHit && grpOfs == 4'h0 && access &&
        !(lastClr_r && lastGrp_r == grpIdx)) begin
      if (!ctrl_r[`PITC_CTRL_CLR_BIT] && rdEn) begin
        clrAll[grpIdx] = 1'b1;
      end else if (ctrl_r[`PITC_CTRL_CLR_BIT] && wrEn) begin
        clrBits[grpIdx] = pwdata[7:0];
      end
    end
  end

  // remembers the last register touched, for the two-clear rule
  // any access elsewhere re-arms the next clear of the flags register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lastClr_r <= 1'b0;
      lastGrp_r <= 2'b00;
    end else if (access) begin
      lastClr_r <= grpHit && grpOfs == 4'h0;
      lastGrp_r <= grpIdx;
    end
  end

  // four status groups
  // each group gets its own bundle of event, block and clear lines
  for (genvar g = 0; g < 4; g++) begin : grp
    pitc_evt_if gi ();
    assign gi.evt = grpEvt[g];
    assign gi.block = block_r[g];
    assign gi.clrBits = clrBits[g];
    assign gi.clrAll = clrAll[g];
    assign gi.lineActive = lineActive;
    assign gi.pendEn = ctrl_r[`PITC_CTRL_PEND_BIT];
    assign grpFlags[g] = gi.flags;
    pitc_evt_group u (
      .clk(clk),
      .rst_n(rst_n),
      .io(gi)
    );
  end

  // any set flag holds the line; only all-clear releases it
  assign anyFlag = |{grpFlags[0], grpFlags[1], grpFlags[2], grpFlags[3]};
  assign lineActive = anyFlag;

  // output line: polarity, suppressed in sleep unless allowed
  // the line follows the flags one cycle late, so it never glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqOut_r <= 1'b1;
    end else begin
      irqOut_r <= ctrl_r[`PITC_CTRL_POL_BIT] ~^ (anyFlag &&
        (!inSleep || therm_r[`PITC_THERM_IRQSLEEP_BIT]));
    end
  end

  // sleep proceeds only with no flag standing
  // a masked flag that is still set holds off sleep too, as the line stays up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleepGo_r <= 1'b0;
      shut_r <= 1'b0;
    end else begin
      sleepGo_r <= sleepRequest && !anyFlag;
      shut_r <= shutHold_r;
    end
  end

  // software-written registers
  // every source starts masked, so stray edges after power-up are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int g = 0; g < 4; g++) begin
        block_r[g] <= `PITC_BLOCK_RST;
      end
      rise_r <= `PITC_RISE_RST;
      fall_r <= `PITC_FALL_RST;
      ctrl_r <= `PITC_CTRL_RST;
      therm_r <= `PITC_THERM_RST;
    end else if (wrEn) begin
      if (grpHit && grpOfs == 4'h4) begin
        block_r[grpIdx] <= pwdata[7:0];
      end
      case (paddr)
        `PITC_OFS_RISE: rise_r <= pwdata[7:0];
        `PITC_OFS_FALL: fall_r <= pwdata[7:0];
        `PITC_OFS_IRQ_CTRL: ctrl_r <= pwdata[7:0];
        `PITC_OFS_THERM_CFG: therm_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data and error, registered for the access phase
  // a flags read clears at the access edge; an event in that cycle still sets
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      if (grpHit) begin
        case (grpOfs)
          4'h0: prdata_r <= {24'h000000, grpFlags[grpIdx]};
          4'h4: prdata_r <= {24'h000000, block_r[grpIdx]};
          default: prdata_r <= {24'h000000,
            grpIdx == 2'd3 ? gpLevel : lvl2_r[grpIdx*8 +: 8]};
        endcase
      end else begin
        case (paddr)
          `PITC_OFS_RISE: prdata_r <= {24'h000000, rise_r};
          `PITC_OFS_FALL: prdata_r <= {24'h000000, fall_r};
          `PITC_OFS_IRQ_CTRL: prdata_r <= {24'h000000, ctrl_r};
          `PITC_OFS_THERM_CFG: prdata_r <= {24'h000000, therm_r};
          `PITC_OFS_SYS_STAT: prdata_r <= {29'h0, shutHold_r, hot_die_event_r, anyFlag};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end else if (access) begin
      // the error flag stands for the access cycle only
      pslverr_r <= 1'b0;
    end
  end

  // outputs straight from their flops, pready tied high
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign irqOut = irqOut_r;
  assign sleepGo = sleepGo_r;
  assign thermShutdown = shut_r;
endmodule

// ---- test/pitc_irq_sva.sv ----
// Purpose: port-level checks of the irq/thermal block
// Assumes: one clock, sync active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`include "pitc_map.svh"
module pitc_irq_sva
  import pitc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [23:0] srcLevel,
  input wire logic [7:0] gpPin,
  input wire logic [7:0] dieTemp,
  input wire logic [1:0] pwrState,
  input wire logic sleepRequest,
  input wire logic irqOut,
  input wire logic sleepGo,
  input wire logic thermShutdown
);
  logic polR;
  wire logic acc = psel && penable;
  wire logic unm = paddr >= 12'h05c;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // follows the line polarity from control writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      polR <= 1'b0;
    end else if (acc && pwrite && paddr == `PITC_OFS_IRQ_CTRL) begin
      polR <= pwdata[`PITC_CTRL_POL_BIT];
    end
  end
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_error: assert property (acc && unm |-> pslverr)
    else $error("no error on unmapped access");
  a_unmapped_zero: assert property (acc && unm && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_values: assert property ($rose(rst_n) |-> irqOut && !sleepGo && !thermShutdown)
    else $error("outputs wrong after reset");
  a_sleep_needs_req: assert property (!sleepRequest |=> !sleepGo)
    else $error("sleep without request");
  a_line_blocks_sleep: assert property (irqOut == polR && $stable(polR) |-> !sleepGo)
    else $error("sleep while line active");
  a_hot_shutdown: assert property ((dieTemp > 8'h94 && pwrState == PITC_ACTIVE) [*2]
    |-> ##[0:6] thermShutdown)
    else $error("no shutdown when overheated");
  a_shutdown_holds: assert property (thermShutdown && dieTemp > 8'h82 && pwrState == PITC_ACTIVE
    |=> thermShutdown)
    else $error("shutdown released while hot");
  a_live_level_read: assert property (acc && !pwrite && paddr == 12'h008
    && srcLevel[7:0] == $past(srcLevel[7:0], 5) |-> prdata[7:0] == srcLevel[7:0])
    else $error("live level read wrong");
endmodule
bind pitc_irq_top pitc_irq_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .srcLevel(srcLevel), .gpPin(gpPin),
  .dieTemp(dieTemp), .pwrState(pwrState), .sleepRequest(sleepRequest),
  .irqOut(irqOut), .sleepGo(sleepGo), .thermShutdown(thermShutdown));

// ---- test/pitc_host_model.sv ----
// Purpose: host processor reaching the block over APB
// Assumes: signals change just after a rising edge
// Notes: waits for pready without assuming a count
`timescale 1ns/1ps
module pitc_host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench of the irq/thermal block
// Assumes: 10 MHz clock, reset held three cycles
// Notes: registers reached through the host model
`timescale 1ns/1ps
module tb
  import pitc_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] e;
  } pitc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irqOut, sleepGo, thermShutdown;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [23:0] srcLevel = 24'h0000a5;
  logic [7:0] gpPin = 8'h00;
  logic [7:0] dieTemp = 8'h19;
  pitc_pwr_t pwrState = PITC_ACTIVE;
  logic sleepRequest = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  pitc_row_t rows [11] = '{'{12'h004, 32'hff}, '{12'h014, 32'hff}, '{12'h024, 32'hff},
    '{12'h034, 32'hff}, '{12'h048, 32'h0}, '{12'h04c, 32'h0}, '{12'h050, 32'h0},
    '{12'h054, 32'h0}, '{12'h000, 32'h0}, '{12'h008, 32'ha5}, '{12'h05c, 32'h0}};
  pitc_irq_top u_pitc_irq_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcLevel(srcLevel), .gpPin(gpPin), .dieTemp(dieTemp),
    .pwrState(pwrState), .sleepRequest(sleepRequest), .irqOut(irqOut), .sleepGo(sleepGo),
    .thermShutdown(thermShutdown));
  pitc_host_model u_pitc_host_model (.clk(clk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  always #50 clk = ~clk;
  // cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    u_pitc_host_model.xfer(1'b0, a, 32'h0, d);
    chk_reg(d, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    u_pitc_host_model.xfer(1'b1, a, v, d);
  endtask
  // one edge on a source line
  task automatic ev(input int b);
    @(posedge clk);
    srcLevel[b] <= ~srcLevel[b];
  endtask
  // lets synchroniser, flag and line settle
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // reset, reset table, then awkward cases
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].e);
    end
    ev(0);
    settle;
    chk_bit(irqOut, 1'b1);
    rdc(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h014, 32'h0);
    ev(0);
    settle;
    chk_bit(irqOut, 1'b0);
    ev(0);
    ev(9);
    settle;
    rdc(12'h000, 32'h1);
    chk_bit(irqOut, 1'b0);
    rdc(12'h010, 32'h2);
    rdc(12'h000, 32'h0);
    settle;
    chk_bit(irqOut, 1'b1);
    ev(0);
    settle;
    wr(12'h004, 32'hff);
    ev(0);
    settle;
    rdc(12'h000, 32'h1);
    wr(12'h004, 32'h0);
    wr(12'h034, 32'h0);
    wr(12'h048, 32'h5);
    wr(12'h04c, 32'h6);
    @(posedge clk) gpPin <= 8'h0f;
    settle;
    @(posedge clk) gpPin <= 8'h00;
    settle;
    rdc(12'h030, 32'h7);
    wr(12'h050, 32'h6);
    ev(0);
    ev(1);
    settle;
    ev(0);
    settle;
    wr(12'h000, 32'h1);
    wr(12'h000, 32'h1);
    rdc(12'h050, 32'h6);
    rdc(12'h000, 32'h3);
    rdc(12'h050, 32'h6);
    wr(12'h000, 32'hff);
    rdc(12'h050, 32'h6);
    rdc(12'h000, 32'h0);
    settle;
    chk_bit(irqOut, 1'b1);
    wr(12'h050, 32'h1);
    settle;
    chk_bit(irqOut, 1'b0);
    wr(12'h050, 32'h0);
    @(posedge clk) dieTemp <= 8'd120;
    settle;
    @(posedge clk) sleepRequest <= 1'b1;
    settle;
    chk_bit(sleepGo, 1'b0);
    rdc(12'h000, 32'h20);
    settle;
    chk_bit(sleepGo, 1'b1);
    @(posedge clk) dieTemp <= 8'd150;
    settle;
    chk_bit(thermShutdown, 1'b1);
    @(posedge clk) dieTemp <= 8'd120;
    settle;
    chk_bit(thermShutdown, 1'b1);
    @(posedge clk) dieTemp <= 8'd100;
    settle;
    chk_bit(thermShutdown, 1'b0);
    @(posedge clk) pwrState <= PITC_BACKUP;
    @(posedge clk) dieTemp <= 8'd150;
    settle;
    chk_bit(thermShutdown, 1'b0);
    // sleep: shutdown and line gated by the thermal config
    wr(12'h054, 32'h6);
    @(posedge clk) pwrState <= PITC_SLEEP;
    settle;
    chk_bit(thermShutdown, 1'b0);
    chk_bit(irqOut, 1'b1);
    wr(12'h054, 32'ha);
    settle;
    chk_bit(irqOut, 1'b0);
    chk_bit(thermShutdown, 1'b1);
    @(posedge clk) dieTemp <= 8'h64;
    settle;
    rdc(12'h000, 32'h20);
    // threshold select two: 123 stays quiet, 127 fires
    @(posedge clk) dieTemp <= 8'h7b;
    settle;
    rdc(12'h054, 32'ha);
    rdc(12'h000, 32'h0);
    @(posedge clk) dieTemp <= 8'h7f;
    settle;
    rdc(12'h054, 32'ha);
    rdc(12'h000, 32'h20);
    // reset again in mid-run
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(12'h000, 32'h0);
    chk_bit(irqOut, 1'b1);
    finish_test();
  end
endmodule
